// ---- src/hecm_mailbox.sv ----
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1 - Host write of inbound byte raises controller mailbox interrupt when enabled
// R2 - Controller read of inbound byte drops controller mailbox interrupt
// R3 - Writing FFh to either mailbox byte makes it zero
// R4 - Inbound byte: host plain read/write; controller writes clear bits written one
// R5 - Outbound byte: controller plain read/write; host writes clear bits written one
// R6 - Any controller write to outbound byte sets outbound write flag
// R7 - Outbound write flag with its mask bit requests both host SMI and serial IRQ
// R8 - Host read of outbound byte withdraws the serial IRQ it caused
// R9 - Host read of outbound byte clears outbound write flag
// R10 - Write flag read-only to host; controller reads zero and writes ignored
// R11 - Any doorbell bit with its mask bit requests host serial IRQ
// R12 - Doorbell bits controller read/write; host writes ones to clear them
// R13 - Host selects register through index port, then accesses data port
// R14 - Mask bit 0 gates write flag toward host; resets to zero
// R15 - Mask bits 7:1 gate doorbell bits toward host; reset to zero
// R16 - Host request is a level; all requests and bytes reset to zero
module hecm_mailbox (
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  // Host index/data port
  input  wire hecm_pkg::hecm_host_req_s host_req,
  output logic [7:0]                   host_rdata,
  // Controller register port
  input  wire hecm_pkg::hecm_ec_req_s   ec_req,
  output logic [7:0]                   ec_rdata,
  // Interrupt requests
  input  wire logic                    aggregator_mailbox_enable,
  output logic                         aggregator_mailbox_bit,
  output logic                         host_serirq_req,
  output logic                         host_smi_req
);

  logic [7:0] host_index_port_reg;
  logic [7:0] host_index_port_next;
  logic [7:0] inbound_command_byte_reg;
  logic [7:0] inbound_command_byte_next;
  logic [7:0] outbound_command_byte_reg;
  logic [7:0] outbound_command_byte_next;
  logic [6:0] software_doorbell_bits_reg;
  logic [6:0] software_doorbell_bits_next;
  logic       outbound_write_flag_reg;
  logic       outbound_write_flag_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic       mbx_irq_reg;
  logic       mbx_irq_next;
  logic       serirq_reg;
  logic       serirq_next;
  logic       smi_reg;
  logic       smi_next;
  logic [7:0] host_rdata_reg;
  logic [7:0] host_rdata_next;
  logic [7:0] ec_rdata_reg;
  logic [7:0] ec_rdata_next;

  logic h_dwr;
  logic h_drd;
  logic h_wr_in;
  logic h_wr_out;
  logic h_wr_src;
  logic h_rd_out;
  logic e_wr_in;
  logic e_wr_out;
  logic e_rd_in;
  logic e_rd_src;

  // Host only reaches data through the latched index
  assign h_dwr    = host_req.wr && (host_req.port == hecm_pkg::PORT_DATA); // [R13]
  assign h_drd    = host_req.rd && (host_req.port == hecm_pkg::PORT_DATA); // [R13]
  assign h_wr_in  = h_dwr && (host_index_port_reg == hecm_pkg::IDX_INBOUND);
  assign h_wr_out = h_dwr && (host_index_port_reg == hecm_pkg::IDX_OUTBOUND);
  assign h_wr_src = h_dwr && (host_index_port_reg == hecm_pkg::IDX_SOURCE);
  assign h_rd_out = h_drd && (host_index_port_reg == hecm_pkg::IDX_OUTBOUND);
  assign e_wr_in  = ec_req.wr && (ec_req.ofs == hecm_pkg::EC_OFS_INBOUND);
  assign e_wr_out = ec_req.wr && (ec_req.ofs == hecm_pkg::EC_OFS_OUTBOUND);
  assign e_rd_in  = ec_req.rd && (ec_req.ofs == hecm_pkg::EC_OFS_INBOUND);
  assign e_rd_src = ec_req.rd && (ec_req.ofs == hecm_pkg::EC_OFS_SOURCE);

  always_comb
  begin
    host_index_port_next        = host_index_port_reg;
    inbound_command_byte_next   = inbound_command_byte_reg;
    outbound_command_byte_next  = outbound_command_byte_reg;
    software_doorbell_bits_next = software_doorbell_bits_reg;
    outbound_write_flag_next    = outbound_write_flag_reg;
    mask_next                   = mask_reg;
    mbx_irq_next                = mbx_irq_reg;
    host_rdata_next             = host_rdata_reg;
    ec_rdata_next               = ec_rdata_reg;

    if (host_req.wr && (host_req.port == hecm_pkg::PORT_INDEX))
    begin
      host_index_port_next = host_req.wdata; // [R13]
    end

    // Inbound byte: host write first, controller clear on top
    if (h_wr_in)
    begin
      inbound_command_byte_next = (host_req.wdata == hecm_pkg::ALL_ONES) ?
                                  hecm_pkg::BYTE_RESET : host_req.wdata; // [R3] [R4]
    end
    if (e_wr_in)
    begin
      inbound_command_byte_next = inbound_command_byte_next & ~ec_req.wdata; // [R4] [R3]
    end

    // Set wins so a host write racing a read is not lost
    if (h_wr_in && aggregator_mailbox_enable)
    begin
      mbx_irq_next = 1'b1; // [R1]
    end
    else if (e_rd_in)
    begin
      mbx_irq_next = 1'b0; // [R2]
    end

    // Outbound byte: controller write overrides a same-cycle host clear
    if (h_wr_out)
    begin
      outbound_command_byte_next = outbound_command_byte_reg & ~host_req.wdata; // [R5] [R3]
    end
    if (e_wr_out)
    begin
      outbound_command_byte_next = (ec_req.wdata == hecm_pkg::ALL_ONES) ?
                                   hecm_pkg::BYTE_RESET : ec_req.wdata; // [R5] [R3]
    end

    if (e_wr_out)
    begin
      outbound_write_flag_next = 1'b1; // [R6]
    end
    else if (h_rd_out)
    begin
      outbound_write_flag_next = 1'b0; // [R9] [R8]
    end

    // Doorbell: host clears ones, controller write stores; bit 0 untouched [R10]
    if (h_wr_src)
    begin
      software_doorbell_bits_next = software_doorbell_bits_reg &
                                    ~host_req.wdata[hecm_pkg::SWI_MSB:hecm_pkg::SWI_LSB]; // [R12]
    end
    if (ec_req.wr && (ec_req.ofs == hecm_pkg::EC_OFS_SOURCE))
    begin
      software_doorbell_bits_next = ec_req.wdata[hecm_pkg::SWI_MSB:hecm_pkg::SWI_LSB]; // [R12]
    end

    if (h_dwr && (host_index_port_reg == hecm_pkg::IDX_MASK))
    begin
      mask_next = host_req.wdata; // [R14] [R15]
    end
    if (ec_req.wr && (ec_req.ofs == hecm_pkg::EC_OFS_MASK))
    begin
      mask_next = ec_req.wdata; // [R14] [R15]
    end

    // Host read data, held until the next read
    if (host_req.rd)
    begin
      host_rdata_next = hecm_pkg::BYTE_RESET;
      if (host_req.port == hecm_pkg::PORT_INDEX)
      begin
        host_rdata_next = host_index_port_reg;
      end
      else
      begin
        unique case (host_index_port_reg)
          hecm_pkg::IDX_INBOUND:  host_rdata_next = inbound_command_byte_reg;
          hecm_pkg::IDX_OUTBOUND: host_rdata_next = outbound_command_byte_reg;
          hecm_pkg::IDX_SOURCE:   host_rdata_next = {software_doorbell_bits_reg,
                                                     outbound_write_flag_reg}; // [R10]
          hecm_pkg::IDX_MASK:     host_rdata_next = mask_reg;
          default:                host_rdata_next = hecm_pkg::BYTE_RESET;
        endcase
      end
    end

    // Controller read data; write flag hidden here
    if (ec_req.rd)
    begin
      unique case (ec_req.ofs)
        hecm_pkg::EC_OFS_INBOUND:  ec_rdata_next = inbound_command_byte_reg;
        hecm_pkg::EC_OFS_OUTBOUND: ec_rdata_next = outbound_command_byte_reg;
        hecm_pkg::EC_OFS_SOURCE:   ec_rdata_next = {software_doorbell_bits_reg, 1'b0}; // [R10]
        hecm_pkg::EC_OFS_MASK:     ec_rdata_next = mask_reg;
        default:                   ec_rdata_next = hecm_pkg::BYTE_RESET;
      endcase
    end

    // Level requests follow the next state so outputs stay pure flops
    smi_next    = outbound_write_flag_next & mask_next[hecm_pkg::WR_FLAG_BIT]; // [R7] [R14] [R16]
    serirq_next = |({software_doorbell_bits_next, outbound_write_flag_next} & mask_next); // [R7] [R11] [R15] [R16]
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_index_port_reg        <= hecm_pkg::BYTE_RESET;
      inbound_command_byte_reg   <= hecm_pkg::BYTE_RESET; // [R16]
      outbound_command_byte_reg  <= hecm_pkg::BYTE_RESET; // [R16]
      software_doorbell_bits_reg <= hecm_pkg::DOORBELL_RST;
      outbound_write_flag_reg    <= 1'b0;
      mask_reg                   <= hecm_pkg::BYTE_RESET; // [R14] [R15]
      mbx_irq_reg                <= 1'b0; // [R16]
      serirq_reg                 <= 1'b0; // [R16]
      smi_reg                    <= 1'b0; // [R16]
      host_rdata_reg             <= hecm_pkg::BYTE_RESET;
      ec_rdata_reg               <= hecm_pkg::BYTE_RESET;
    end
    else if (ce)
    begin
      host_index_port_reg        <= host_index_port_next;
      inbound_command_byte_reg   <= inbound_command_byte_next;
      outbound_command_byte_reg  <= outbound_command_byte_next;
      software_doorbell_bits_reg <= software_doorbell_bits_next;
      outbound_write_flag_reg    <= outbound_write_flag_next;
      mask_reg                   <= mask_next;
      mbx_irq_reg                <= mbx_irq_next;
      serirq_reg                 <= serirq_next;
      smi_reg                    <= smi_next;
      host_rdata_reg             <= host_rdata_next;
      ec_rdata_reg               <= ec_rdata_next;
    end
  end

  assign host_rdata             = host_rdata_reg;
  assign ec_rdata               = ec_rdata_reg;
  assign aggregator_mailbox_bit = mbx_irq_reg;
  assign host_serirq_req        = serirq_reg;
  assign host_smi_req           = smi_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_mbx_irq_set: assert property (ce && h_wr_in && aggregator_mailbox_enable |=> aggregator_mailbox_bit) // [R1]
    else $error("mailbox irq not raised by host write");
  a_mbx_irq_clr: assert property (ce && e_rd_in && !h_wr_in |=> !aggregator_mailbox_bit) // [R2]
    else $error("mailbox irq not dropped by controller read");
  a_ff_clears_in: assert property (ce && h_wr_in && !e_wr_in && host_req.wdata == 8'hFF
                                   |=> inbound_command_byte_reg == 8'h00) // [R3]
    else $error("inbound byte not zeroed by FFh");
  a_in_w1c: assert property (ce && e_wr_in && !h_wr_in
                             |=> inbound_command_byte_reg ==
                                 ($past(inbound_command_byte_reg) & ~$past(ec_req.wdata))) // [R4]
    else $error("inbound byte controller clear wrong");
  a_out_w1c: assert property (ce && h_wr_out && !e_wr_out
                              |=> outbound_command_byte_reg ==
                                  ($past(outbound_command_byte_reg) & ~$past(host_req.wdata))) // [R5]
    else $error("outbound byte host clear wrong");
  a_flag_set: assert property (ce && e_wr_out
                               |=> outbound_write_flag_reg && ($past(host_req.rd) || host_rdata == $past(host_rdata))) // [R6]
    else $error("write flag not set");
  a_smi_level: assert property (host_smi_req == (outbound_write_flag_reg && mask_reg[0])) // [R7]
    else $error("smi request mismatch");
  a_flag_read_clr: assert property (ce && h_rd_out && !e_wr_out |=> !outbound_write_flag_reg) // [R9]
    else $error("write flag not cleared by host read");
  a_serirq_drop: assert property (ce && h_rd_out && !e_wr_out && mask_reg[7:1] == 7'h00 && !h_dwr
                                  && !(ec_req.wr && ec_req.ofs == hecm_pkg::EC_OFS_MASK) |=> !host_serirq_req) // [R8]
    else $error("serial irq not withdrawn");
  a_ec_flag_hidden: assert property (ce && e_rd_src |=> ec_rdata[0] == 1'b0) // [R10]
    else $error("write flag visible to controller");
  a_serirq_level: assert property (host_serirq_req ==
                                   |({software_doorbell_bits_reg, outbound_write_flag_reg} & mask_reg)) // [R11]
    else $error("serial irq level mismatch");
  a_swi_host_clr: assert property (ce && h_wr_src && !(ec_req.wr && ec_req.ofs == hecm_pkg::EC_OFS_SOURCE)
                                   |=> (software_doorbell_bits_reg & $past(host_req.wdata[7:1])) == 7'h00) // [R12]
    else $error("doorbell bits not cleared by host");

endmodule : hecm_mailbox

`default_nettype wire

// ---- pkg/hecm_pkg.sv ----
package hecm_pkg;

  // Controller-side offsets
  localparam logic [8:0] EC_OFS_INBOUND  = 9'h100;
  localparam logic [8:0] EC_OFS_OUTBOUND = 9'h104;
  localparam logic [8:0] EC_OFS_SOURCE   = 9'h108;
  localparam logic [8:0] EC_OFS_MASK     = 9'h10C;

  // Host index values behind the data port
  localparam logic [7:0] IDX_INBOUND  = 8'h00;
  localparam logic [7:0] IDX_OUTBOUND = 8'h01;
  localparam logic [7:0] IDX_SOURCE   = 8'h02;
  localparam logic [7:0] IDX_MASK     = 8'h03;

  // Host port select
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA  = 1'b1;

  // Values and field positions
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [6:0] DOORBELL_RST = 7'h00;
  localparam int         WR_FLAG_BIT  = 0;
  localparam int         SWI_LSB      = 1;
  localparam int         SWI_MSB      = 7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       port;
    logic [7:0] wdata;
  } hecm_host_req_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] ofs;
    logic [7:0] wdata;
  } hecm_ec_req_s;

endpackage : hecm_pkg

// ---- verification/hecm_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module hecm_host_model (
  // Clock
  input  wire logic                     clk,
  // Host index/data port
  output var hecm_pkg::hecm_host_req_s  host_req,
  input  wire logic [7:0]               host_rdata
);
  initial host_req = '0;

  // Released lines show inverted leftovers, so a stale value never looks valid
  task automatic cycle(input logic port, input logic wr, input logic [7:0] wdata);
    @(negedge clk);
    host_req = '{wr: wr, rd: !wr, port: port, wdata: wdata};
    @(negedge clk);
    host_req = '{wr: 1'b0, rd: 1'b0, port: !port, wdata: ~wdata};
  endtask : cycle

  task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
    cycle(hecm_pkg::PORT_INDEX, 1'b1, idx);
    cycle(hecm_pkg::PORT_DATA, 1'b1, data);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] idx, output logic [7:0] data);
    cycle(hecm_pkg::PORT_INDEX, 1'b1, idx);
    cycle(hecm_pkg::PORT_DATA, 1'b0, ~idx);
    data = host_rdata;
  endtask : read_reg
endmodule : hecm_host_model

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic                     clk;
  logic                     rstn;
  logic                     ce;
  logic                     mb_enable;
  hecm_pkg::hecm_ec_req_s   ec_req;
  hecm_pkg::hecm_host_req_s host_req;
  logic [7:0]               host_rdata;
  logic [7:0]               ec_rdata;
  logic                     mb_irq;
  logic                     serirq;
  logic                     smi;
  logic [7:0]               d;
  int                       fails = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;

  hecm_mailbox dut (.clk(clk), .rstn(rstn), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
    .ec_req(ec_req), .ec_rdata(ec_rdata), .aggregator_mailbox_enable(mb_enable),
    .aggregator_mailbox_bit(mb_irq), .host_serirq_req(serirq), .host_smi_req(smi));
  hecm_host_model hm (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));

  always #4 clk = ~clk;

  // Whole run needs about 120 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic ec_cycle(input logic wr, input logic [8:0] ofs, input logic [7:0] wdata);
    @(negedge clk);
    ec_req = '{wr: wr, rd: !wr, ofs: ofs, wdata: wdata};
    @(negedge clk);
    ec_req = '{wr: 1'b0, rd: 1'b0, ofs: ~ofs, wdata: ~wdata};
  endtask : ec_cycle

  task automatic ec_read(input logic [8:0] ofs, output logic [7:0] data);
    ec_cycle(1'b0, ofs, 8'h00);
    data = ec_rdata;
  endtask : ec_read

  task automatic t_reset();
    logic [8:0] ofs [4];
    ofs = '{hecm_pkg::EC_OFS_INBOUND, hecm_pkg::EC_OFS_OUTBOUND, hecm_pkg::EC_OFS_SOURCE, hecm_pkg::EC_OFS_MASK};
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    foreach (ofs[i])
    begin
      ec_read(ofs[i], d);
      chk(d, 8'h00);
    end
  endtask : t_reset

  task automatic t_inbound();
    mb_enable = 1'b1;
    hm.write_reg(hecm_pkg::IDX_INBOUND, 8'hA5);
    chk({5'h00, mb_irq, serirq, smi}, 8'h04);
    hm.read_reg(hecm_pkg::IDX_INBOUND, d);
    chk(d, 8'hA5);
    ec_read(hecm_pkg::EC_OFS_INBOUND, d);
    chk(d, 8'hA5);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_INBOUND, 8'h05);
    hm.read_reg(hecm_pkg::IDX_INBOUND, d);
    chk(d, 8'hA0);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_INBOUND, 8'hFF);
    ec_read(hecm_pkg::EC_OFS_INBOUND, d);
    chk(d, 8'h00);
    mb_enable = 1'b0;
    hm.write_reg(hecm_pkg::IDX_INBOUND, 8'h3C);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    hm.write_reg(hecm_pkg::IDX_INBOUND, 8'hFF);
    hm.read_reg(hecm_pkg::IDX_INBOUND, d);
    chk(d, 8'h00);
  endtask : t_inbound

  task automatic t_outbound();
    hm.write_reg(hecm_pkg::IDX_MASK, 8'h01);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_OUTBOUND, 8'h5A);
    chk({5'h00, mb_irq, serirq, smi}, 8'h03);
    hm.read_reg(hecm_pkg::IDX_SOURCE, d);
    chk(d, 8'h01);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_SOURCE, 8'h01);
    ec_read(hecm_pkg::EC_OFS_SOURCE, d);
    chk(d, 8'h00);
    hm.read_reg(hecm_pkg::IDX_OUTBOUND, d);
    chk(d, 8'h5A);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    hm.write_reg(hecm_pkg::IDX_OUTBOUND, 8'h0F);
    ec_read(hecm_pkg::EC_OFS_OUTBOUND, d);
    chk(d, 8'h50);
    hm.write_reg(hecm_pkg::IDX_OUTBOUND, 8'hFF);
    ec_read(hecm_pkg::EC_OFS_OUTBOUND, d);
    chk(d, 8'h00);
  endtask : t_outbound

  task automatic t_doorbell();
    hm.write_reg(hecm_pkg::IDX_MASK, 8'h00);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_OUTBOUND, 8'h11);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    hm.read_reg(hecm_pkg::IDX_OUTBOUND, d);
    ec_cycle(1'b1, hecm_pkg::EC_OFS_SOURCE, 8'h07);
    ec_read(hecm_pkg::EC_OFS_SOURCE, d);
    chk(d, 8'h06);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
    hm.write_reg(hecm_pkg::IDX_MASK, 8'h04);
    chk({5'h00, mb_irq, serirq, smi}, 8'h02);
    hm.write_reg(hecm_pkg::IDX_SOURCE, 8'h04);
    hm.read_reg(hecm_pkg::IDX_SOURCE, d);
    chk(d, 8'h02);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
  endtask : t_doorbell

  task automatic t_refused();
    ec_read(9'h110, d);
    chk(d, 8'h00);
    hm.read_reg(8'h10, d);
    chk(d, 8'h00);
    // Frozen clock enable must swallow the write
    ce = 1'b0;
    ec_cycle(1'b1, hecm_pkg::EC_OFS_OUTBOUND, 8'h77);
    ce = 1'b1;
    ec_read(hecm_pkg::EC_OFS_OUTBOUND, d);
    chk(d, 8'h11);
    chk({5'h00, mb_irq, serirq, smi}, 8'h00);
  endtask : t_refused

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    mb_enable = 1'b0;
    ec_req = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_inbound();
    t_outbound();
    t_doorbell();
    t_refused();
    // Second reset with a live request and dirty registers
    ec_cycle(1'b1, hecm_pkg::EC_OFS_SOURCE, 8'h04);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    conclude();
  end
endmodule : testbench

`default_nettype wire
